// ===== rtl/spfm_pkg.sv
package spfm_pkg;

  // special function register addresses
  localparam logic [7:0] SFR_POWER_CTRL  = 8'h87;
  localparam logic [7:0] SFR_SERIAL_CTRL = 8'h98;
  localparam logic [7:0] SFR_SERIAL_BUF  = 8'h99;

  // serial_port_control field positions
  localparam int CTL_MODE_HI     = 7;
  localparam int CTL_MODE_LO     = 6;
  localparam int CTL_FRAME_CHECK = 5;
  localparam int CTL_RX_ENABLE   = 4;
  localparam int CTL_TX_NINTH    = 3;
  localparam int CTL_RX_NINTH    = 2;
  localparam int CTL_TX_DONE     = 1;
  localparam int CTL_RX_DONE     = 0;

  // power_mode_control field positions
  localparam int PWR_BAUD_DOUBLER = 7;

  localparam logic [7:0] SERIAL_CTRL_RST = 8'h00;
  localparam logic [7:0] POWER_CTRL_RST  = 8'h00;
  localparam logic [7:0] SERIAL_BUF_RST  = 8'h00;

  // rate figures as divides of the core clock; TIMER1_BIT_DIV divides timer 1 overflows
  localparam int OVERSAMPLE      = 16;
  localparam int SHIFT_MODE_DIV  = 12;
  localparam int FIXED_SLOW_DIV  = 64;
  localparam int FIXED_FAST_DIV  = 32;
  localparam int TIMER1_BIT_DIV  = 32;
  localparam logic [3:0] SHIFT_HALF_CNT = 4'(SHIFT_MODE_DIV / 2);
  localparam logic [3:0] FIXED_SLOW_CNT = 4'(FIXED_SLOW_DIV / OVERSAMPLE);
  localparam logic [3:0] FIXED_FAST_CNT = 4'(FIXED_FAST_DIV / OVERSAMPLE);
  localparam logic [3:0] TIMER1_SLOW_CNT = 4'(TIMER1_BIT_DIV / OVERSAMPLE);
  localparam logic [3:0] TIMER1_FAST_CNT = 4'h1;

  // bits shifted after the start bit: data plus stop, or data, ninth and stop; shift mode moves eight data bits and no start
  localparam logic [3:0] BITS_UART8 = 4'h9;
  localparam logic [3:0] BITS_UART9 = 4'hA;
  localparam logic [3:0] SHIFT_BITS = 4'h8;

  typedef enum logic [1:0] {
    SPFM_MODE_SHIFT   = 2'b00,
    SPFM_MODE_UART8   = 2'b01,
    SPFM_MODE_UART9_F = 2'b10,
    SPFM_MODE_UART9_V = 2'b11
  } spfm_mode_t;

  typedef enum logic [1:0] {
    SPFM_RX_IDLE  = 2'b00,
    SPFM_RX_START = 2'b01,
    SPFM_RX_DATA  = 2'b10
  } spfm_rx_state_t;

endpackage : spfm_pkg

// ===== rtl/spfm_pulse_div.sv
`timescale 1ns/10ps
`default_nettype none
module spfm_pulse_div
  import spfm_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic         en,
  input  wire logic [W-1:0] divisor,
  output logic              pulse
);

  generate
    if (W < 1) begin : gChk
      $error("spfm_pulse_div: W must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         pulse;
  } spfm_div_t;

  spfm_div_t s_q;
  spfm_div_t s_d;

  // a divisor of zero behaves as one
  always_comb begin
    s_d       = s_q;
    s_d.pulse = 1'b0;
    if (en) begin
      if ((s_q.cnt + W'(1)) >= divisor) begin
        s_d.cnt   = '0;
        s_d.pulse = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pulse = s_q.pulse;

endmodule : spfm_pulse_div
`default_nettype wire

// ===== rtl/spfm_bit_timer.sv
`timescale 1ns/10ps
`default_nettype none
module spfm_bit_timer
  import spfm_pkg::*;
#(
  parameter int OVS = OVERSAMPLE
) (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic tick,
  input  wire logic restart,
  output logic      midPulse,
  output logic      endPulse
);

  localparam int CW = $clog2(OVS);

  generate
    if (OVS < 4 || (1 << CW) != OVS) begin : gChk
      $error("spfm_bit_timer: OVS must be a power of two, at least 4");
    end
  endgenerate

  typedef struct packed {
    logic [CW-1:0] cnt;
  } spfm_bt_t;

  spfm_bt_t s_q;
  spfm_bt_t s_d;

  always_comb begin
    s_d = s_q;
    if (restart) begin
      s_d.cnt = '0;
    end else if (tick) begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  // mid-bit sampling point and bit boundary, both on a tick
  assign midPulse = tick && !restart && (s_q.cnt == CW'(OVS / 2 - 1));
  assign endPulse = tick && !restart && (s_q.cnt == CW'(OVS - 1));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : spfm_bit_timer
`default_nettype wire

// ===== rtl/spfm_serial_port.sv
//
// Contract
// - both mode bits clear: shift register, clock on txd, core/12, eight bits
// - shift mode: buffer write sends eight bits on data line, lsb first
// - shift mode receive starts when receive enable is 1 and rx done is 0
// - mode 1 frame: start 0, eight data bits lsb first, stop 1
// - variable rates come from timer 1, timer 2 or the dedicated rate timer
// - 8-bit transmit loads stop 1 as ninth bit; tx done when stop appears
// - async receive starts on falling line edge, shifts bits if start valid
// - without enhanced port, accept only while rx done flag is 0
// - 8-bit mode with frame check: accept only if stop bit is 1
// - failed acceptance discards frame, rx done flag is not set
// - accepted 8-bit frame: data to buffer, stop to ninth bit, set rx done
// - mode 2 runs 9-bit at core/64, or core/32 with baud doubler; here dedicated rate enable keeps mode 2 at core/64
// - 9-bit frame: start 0, eight data, ninth bit, stop 1
// - 9-bit transmit waits next rate tick, tx done when stop appears
// - 9-bit with frame check: accept only frames whose ninth bit is 1
// - accepted 9-bit frame: data to buffer, ninth to ninth bit, set rx done
// - mode 3 equals mode 2 but with timer derived rate
// - any write to the serial buffer starts a transmission
// - async receivers react to start bits only while receive enable is 1
// - enhanced port: accept whatever the rx done flag; overwrite sets error, buffer read clears it
// - dedicated rate enable ignores baud doubler and timer 2 selects
//
`timescale 1ns/10ps
`default_nettype none
module spfm_serial_port
  import spfm_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWrEn,
  input  wire logic [7:0] sfrWrData,
  input  wire logic       sfrRdEn,
  output logic      [7:0] sfrRdData,
  input  wire logic       rxdIn,
  output logic            rxdOut,
  output logic            rxdOe,
  output logic            txdOut,
  input  wire logic       timer1Ovf,
  input  wire logic       timer2TxOvf,
  input  wire logic       timer2RxOvf,
  input  wire logic       rateTimerTick,
  input  wire logic       timer2TxRateSelect,
  input  wire logic       timer2RxRateSelect,
  input  wire logic       dedicatedRateGenEnable,
  input  wire logic       enhancedPortEnable,
  output logic            overwriteErr
);

  typedef struct packed {
    logic [7:0]     ctl;
    logic [7:0]     pwr;
    logic [7:0]     rxBuf;
    logic [7:0]     rdData;
    logic           ovrErr;
    logic           txd;
    logic           rxdOut;
    logic           rxdOe;
    logic           txPend;
    logic           txBusy;
    logic [3:0]     txCnt;
    logic [9:0]     txSh;
    spfm_rx_state_t rxState;
    logic [3:0]     rxCnt;
    logic [9:0]     rxSh;
    logic           rxPrev;
    logic           m0Busy;
    logic           m0Rx;
    logic           m0Clk;
    logic [3:0]     m0Cnt;
    logic [7:0]     m0Sh;
  } spfm_state_t;

  spfm_state_t s_q;
  spfm_state_t s_d;

  spfm_mode_t mode;
  logic       nineBit;
  logic       baudDbl;
  logic       m0Tick;
  logic       fixTick;
  logic       t1Tick;
  logic       txTick;
  logic       rxTick;
  logic       txRestart;
  logic       rxRestart;
  logic       txMid;
  logic       txEnd;
  logic       rxMid;
  logic       rxEnd;

  assign mode    = spfm_mode_t'({s_q.ctl[CTL_MODE_HI], s_q.ctl[CTL_MODE_LO]});
  assign nineBit = s_q.ctl[CTL_MODE_HI];
  // the doubler is ignored while the dedicated rate timer is in use
  assign baudDbl = s_q.pwr[PWR_BAUD_DOUBLER] && !dedicatedRateGenEnable;

  // half period of the shift clock
  spfm_pulse_div #(.W(4)) uShiftDiv (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .en      (1'b1),
    .divisor (SHIFT_HALF_CNT),
    .pulse   (m0Tick)
  );

  // oversample tick for the fixed-rate 9-bit mode
  spfm_pulse_div #(.W(4)) uFixedDiv (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .en      (1'b1),
    .divisor (baudDbl ? FIXED_FAST_CNT : FIXED_SLOW_CNT),
    .pulse   (fixTick)
  );

  // timer 1 overflows feed the bit clock at 2^doubler/32 of their rate
  spfm_pulse_div #(.W(4)) uTimer1Div (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .en      (timer1Ovf),
    .divisor (baudDbl ? TIMER1_FAST_CNT : TIMER1_SLOW_CNT),
    .pulse   (t1Tick)
  );

  // rate source for each direction
  always_comb begin
    if (mode == SPFM_MODE_UART9_F) begin
      txTick = fixTick;
      rxTick = fixTick;
    end else if (dedicatedRateGenEnable) begin
      txTick = rateTimerTick;
      rxTick = rateTimerTick;
    end else begin
      txTick = timer2TxRateSelect ? timer2TxOvf : t1Tick;
      rxTick = timer2RxRateSelect ? timer2RxOvf : t1Tick;
    end
  end

  assign txRestart = s_q.txPend && txTick && mode != SPFM_MODE_SHIFT;
  assign rxRestart = (s_q.rxState == SPFM_RX_IDLE) && s_q.rxPrev && !rxdIn;

  spfm_bit_timer #(.OVS(OVERSAMPLE)) uTxTimer (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .tick     (txTick),
    .restart  (txRestart),
    .midPulse (txMid),
    .endPulse (txEnd)
  );

  spfm_bit_timer #(.OVS(OVERSAMPLE)) uRxTimer (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .tick     (rxTick),
    .restart  (rxRestart),
    .midPulse (rxMid),
    .endPulse (rxEnd)
  );

  always_comb begin
    logic [9:0] newSh;
    logic [7:0] rxData;
    logic       rxNinth;
    logic       accept;
    logic [3:0] rxLast;
    newSh   = {rxdIn, s_q.rxSh[9:1]};
    rxData  = 8'h00;
    rxNinth = 1'b0;
    accept  = 1'b0;
    rxLast  = nineBit ? BITS_UART9 : BITS_UART8;
    s_d     = s_q;
    s_d.rxPrev = rxdIn;

    // software writes first; hardware events below override them
    if (sfrWrEn) begin
      if (sfrAddr == SFR_SERIAL_CTRL) begin
        s_d.ctl = sfrWrData;
      end else if (sfrAddr == SFR_POWER_CTRL) begin
        s_d.pwr = sfrWrData;
      end else if (sfrAddr == SFR_SERIAL_BUF) begin
        if (mode == SPFM_MODE_SHIFT) begin
          s_d.m0Busy = 1'b1;
          s_d.m0Rx   = 1'b0;
          s_d.m0Sh   = sfrWrData;
          s_d.m0Cnt  = 4'h0;
          s_d.m0Clk  = 1'b0;
          s_d.rxdOut = sfrWrData[0];
          s_d.rxdOe  = 1'b1;
        end else begin
          s_d.txPend = 1'b1;
          s_d.txBusy = 1'b0;
          // ninth position: stop bit in 8-bit mode, programmable in 9-bit
          s_d.txSh   = {1'b1, nineBit ? s_q.ctl[CTL_TX_NINTH] : 1'b1, sfrWrData};
          s_d.txCnt  = nineBit ? BITS_UART9 : BITS_UART8;
        end
      end
    end

    // register read, answered one cycle later; unmapped reads give zero
    if (sfrRdEn) begin
      if (sfrAddr == SFR_SERIAL_CTRL) begin
        s_d.rdData = s_q.ctl;
      end else if (sfrAddr == SFR_POWER_CTRL) begin
        s_d.rdData = s_q.pwr;
      end else if (sfrAddr == SFR_SERIAL_BUF) begin
        s_d.rdData = s_q.rxBuf;
        s_d.ovrErr = 1'b0;
      end else begin
        s_d.rdData = 8'h00;
      end
    end

    // shift register mode start of reception
    if (mode == SPFM_MODE_SHIFT && !s_d.m0Busy && s_q.ctl[CTL_RX_ENABLE]
        && !s_q.ctl[CTL_RX_DONE]) begin
      s_d.m0Busy = 1'b1;
      s_d.m0Rx   = 1'b1;
      s_d.m0Cnt  = 4'h0;
      s_d.m0Clk  = 1'b0;
      s_d.rxdOe  = 1'b0;
    end

    // shift clock: low half presents data, rising edge samples
    if (s_q.m0Busy && m0Tick && mode == SPFM_MODE_SHIFT) begin
      if (!s_q.m0Clk) begin
        s_d.m0Clk = 1'b1;
        if (s_q.m0Rx) begin
          s_d.m0Sh = {rxdIn, s_q.m0Sh[7:1]};
        end
      end else begin
        s_d.m0Clk = 1'b0;
        s_d.m0Cnt = s_q.m0Cnt + 4'h1;
        if (s_q.m0Cnt == SHIFT_BITS - 4'h1) begin
          s_d.m0Busy = 1'b0;
          s_d.rxdOe  = 1'b0;
          if (s_q.m0Rx) begin
            s_d.rxBuf = s_q.m0Sh;
            s_d.ctl[CTL_RX_DONE] = 1'b1;
          end else begin
            s_d.ctl[CTL_TX_DONE] = 1'b1;
          end
        end else if (!s_q.m0Rx) begin
          s_d.m0Sh   = {1'b0, s_q.m0Sh[7:1]};
          s_d.rxdOut = s_q.m0Sh[1];
        end
      end
    end
    if (mode != SPFM_MODE_SHIFT) begin
      s_d.m0Busy = 1'b0;
      s_d.m0Clk  = 1'b0;
      s_d.rxdOe  = 1'b0;
    end

    // asynchronous transmitter
    if (txRestart) begin
      s_d.txPend = 1'b0;
      s_d.txBusy = 1'b1;
      s_d.txd    = 1'b0;
    end else if (s_q.txBusy && txEnd) begin
      if (s_q.txCnt == 4'h0) begin
        s_d.txBusy = 1'b0;
      end else begin
        s_d.txd   = s_q.txSh[0];
        s_d.txSh  = {1'b1, s_q.txSh[9:1]};
        s_d.txCnt = s_q.txCnt - 4'h1;
        if (s_q.txCnt == 4'h1) begin
          s_d.ctl[CTL_TX_DONE] = 1'b1;
        end
      end
    end
    if (mode == SPFM_MODE_SHIFT) begin
      s_d.txBusy = 1'b0;
      s_d.txPend = 1'b0;
      // next-state busy: the clock parks high at the end, with no extra edge
      s_d.txd    = s_d.m0Busy ? s_d.m0Clk : 1'b1;
    end else if (!s_d.txBusy) begin
      s_d.txd = 1'b1;
    end

    // asynchronous receiver
    case (s_q.rxState)
      SPFM_RX_IDLE: begin
        if (rxRestart && s_q.ctl[CTL_RX_ENABLE] && mode != SPFM_MODE_SHIFT) begin
          s_d.rxState = SPFM_RX_START;
        end
      end
      SPFM_RX_START: begin
        if (rxMid) begin
          if (rxdIn) begin
            s_d.rxState = SPFM_RX_IDLE;
          end else begin
            s_d.rxState = SPFM_RX_DATA;
            s_d.rxCnt   = 4'h0;
          end
        end
      end
      SPFM_RX_DATA: begin
        if (rxMid) begin
          s_d.rxSh  = newSh;
          s_d.rxCnt = s_q.rxCnt + 4'h1;
          if (s_q.rxCnt == rxLast - 4'h1) begin
            s_d.rxState = SPFM_RX_IDLE;
            if (nineBit) begin
              rxData  = newSh[7:0];
              rxNinth = newSh[8];
            end else begin
              rxData  = newSh[8:1];
              rxNinth = newSh[9];
            end
            accept = (enhancedPortEnable || !s_q.ctl[CTL_RX_DONE])
                     && (!s_q.ctl[CTL_FRAME_CHECK] || rxNinth);
            // a refused frame leaves buffer and flags untouched
            if (accept) begin
              s_d.rxBuf = rxData;
              s_d.ctl[CTL_RX_NINTH] = rxNinth;
              s_d.ctl[CTL_RX_DONE]  = 1'b1;
              if (s_q.ctl[CTL_RX_DONE]) begin
                s_d.ovrErr = 1'b1;
              end
            end
          end
        end
      end
      default: begin
        s_d.rxState = SPFM_RX_IDLE;
      end
    endcase
    // leaving the asynchronous modes abandons a frame in progress
    if (mode == SPFM_MODE_SHIFT) begin
      s_d.rxState = SPFM_RX_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q         <= '0;
      s_q.ctl     <= SERIAL_CTRL_RST;
      s_q.pwr     <= POWER_CTRL_RST;
      s_q.rxBuf   <= SERIAL_BUF_RST;
      s_q.txd     <= 1'b1;
      s_q.rxPrev  <= 1'b1;
      s_q.txSh    <= 10'h3FF;
      s_q.rxState <= SPFM_RX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign sfrRdData    = s_q.rdData;
  assign txdOut       = s_q.txd;
  assign rxdOut       = s_q.rxdOut;
  assign rxdOe        = s_q.rxdOe;
  assign overwriteErr = s_q.ovrErr;

endmodule : spfm_serial_port
`default_nettype wire

// ===== tb/spfm_serial_port_props.sv
`timescale 1ns/10ps
`default_nettype none
module spfm_serial_port_props
  import spfm_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic [7:0] sfrAddr,
  input wire logic       sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic       sfrRdEn,
  input wire logic [7:0] sfrRdData,
  input wire logic       rxdOut,
  input wire logic       rxdOe,
  input wire logic       txdOut,
  input wire logic       dedicatedRateGenEnable,
  input wire logic       overwriteErr
);
  logic [7:0] ctlQ;
  logic [7:0] pwrQ;
  logic [9:0] lowQ;
  logic       rdCtl;
  logic       rdPwr;
  logic       mapped;
  assign rdCtl = sfrRdEn && !sfrWrEn && sfrAddr == SFR_SERIAL_CTRL;
  assign rdPwr = sfrRdEn && !sfrWrEn && sfrAddr == SFR_POWER_CTRL;
  assign mapped = sfrAddr inside {SFR_POWER_CTRL, SFR_SERIAL_CTRL, SFR_SERIAL_BUF};

  // software view of the control bits plus the length of each low run on the line
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctlQ <= 8'h00;
      pwrQ <= 8'h00;
      lowQ <= 10'h000;
    end else begin
      if (sfrWrEn && sfrAddr == SFR_SERIAL_CTRL) ctlQ <= sfrWrData;
      if (sfrWrEn && sfrAddr == SFR_POWER_CTRL) pwrQ <= sfrWrData;
      lowQ <= txdOut ? 10'h000 : lowQ + 10'h001;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  unmapped_read_a: assert property (sfrRdEn && !mapped |=> sfrRdData == 8'h00)
    else $error("unmapped read gave data");
  read_hold_a: assert property (!sfrRdEn |=> $stable(sfrRdData))
    else $error("read data moved without a read");
  ctl_readback_a: assert property (rdCtl |=> sfrRdData[7:3] == $past(ctlQ[7:3]))
    else $error("control read mismatch");
  pwr_readback_a: assert property (rdPwr |=> sfrRdData == $past(pwrQ))
    else $error("power control read mismatch");
  ovw_clear_a: assert property ($fell(overwriteErr) |-> $past(sfrRdEn && sfrAddr == SFR_SERIAL_BUF))
    else $error("overwrite flag cleared without buffer read");
  oe_mode0_a: assert property (rxdOe |-> $past(ctlQ[7:6]) == 2'b00)
    else $error("data pin driven outside shift mode");
  clk_high_a: assert property ($rose(txdOut) && rxdOe |-> txdOut [*6])
    else $error("shift clock high phase wrong");
  clk_low_a: assert property ($fell(txdOut) && $past(rxdOe) && rxdOe |-> !txdOut [*6])
    else $error("shift clock low phase wrong");
  data_hold_a: assert property (rxdOe && txdOut && $past(txdOut) |-> $stable(rxdOut))
    else $error("shift data moved while clock high");
  bit_time_a: assert property ($rose(txdOut) && ctlQ[7:6] == 2'b10 && !pwrQ[PWR_BAUD_DOUBLER]
    && !dedicatedRateGenEnable |-> lowQ[5:0] == 6'h00) else $error("fixed rate bit time wrong");

  shift_tx_c: cover property ($rose(rxdOe));
  overwrite_c: cover property ($rose(overwriteErr));
  async_tx_c: cover property ($fell(txdOut) && !rxdOe);
endmodule : spfm_serial_port_props

bind spfm_serial_port spfm_serial_port_props chk_u (
  .mclk(mclk), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
  .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .rxdOut(rxdOut), .rxdOe(rxdOe), .txdOut(txdOut),
  .dedicatedRateGenEnable(dedicatedRateGenEnable), .overwriteErr(overwriteErr)
);
`default_nettype wire

// ===== tb/spfm_remote_node.sv
`timescale 1ns/10ps
`default_nettype none
module spfm_remote_node (
  input  wire logic mclk,
  input  wire logic lineIn,
  input  wire logic shiftIn,
  output logic      lineOut
);
  // marking line idles high between frames
  initial lineOut = 1'b1;

  task automatic send(input logic [10:0] f, input int n, input int per);
    @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      lineOut <= f[i];
      repeat (per) @(posedge mclk);
    end
    lineOut <= 1'b1;
  endtask : send

  // samples mid-bit; bits beyond n read as marking level
  task automatic cap(output logic [10:0] f, input int n, input int per);
    f = 11'h7FF;
    @(negedge lineIn);
    repeat (per / 2) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      f[i] = lineIn;
      if (i < n - 1) repeat (per) @(posedge mclk);
    end
  endtask : cap

  task automatic shift_cap(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge lineIn);
      b[i] = shiftIn;
    end
  endtask : shift_cap

  task automatic shift_feed(input logic [7:0] b);
    @(posedge mclk);
    lineOut <= b[0];
    for (int i = 1; i < 8; i++) begin
      @(posedge lineIn);
      @(negedge lineIn);
      lineOut <= b[i];
    end
    @(posedge lineIn);
    repeat (6) @(posedge mclk);
    // released data line: show the opposite level, not a stale bit
    lineOut <= ~b[7];
  endtask : shift_feed
endmodule : spfm_remote_node
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb;
  import spfm_pkg::*;
  localparam int PER_TICK = OVERSAMPLE * 4;
  logic       mclk;
  logic       rst_b;
  logic [7:0] sfrAddr;
  logic       sfrWrEn;
  logic [7:0] sfrWrData;
  logic       sfrRdEn;
  logic [7:0] sfrRdData;
  logic       rxdIn;
  logic       rxdOut;
  logic       rxdOe;
  logic       txdOut;
  logic       rateTimerTick = 1'b0;
  logic       timer1Ovf = 1'b0;
  logic       dedicatedRateGenEnable;
  logic       enhancedPortEnable;
  logic       overwriteErr;
  logic [1:0] tickCnt = 2'h0;
  logic [7:0] b;
  logic [7:0] d;
  logic [10:0] f;
  int         failures = 0;
  int         n_compared = 0;

  spfm_serial_port dut_u (
    .mclk(mclk), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
    .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe(rxdOe), .txdOut(txdOut),
    .timer1Ovf(timer1Ovf), .timer2TxOvf(1'b0), .timer2RxOvf(1'b0),
    .rateTimerTick(rateTimerTick), .timer2TxRateSelect(1'b0), .timer2RxRateSelect(1'b0),
    .dedicatedRateGenEnable(dedicatedRateGenEnable),
    .enhancedPortEnable(enhancedPortEnable), .overwriteErr(overwriteErr)
  );
  spfm_remote_node rem_u (.mclk(mclk), .lineIn(txdOut), .shiftIn(rxdOut), .lineOut(rxdIn));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // dedicated rate timer stand-in: one 16x tick every four core clocks
  always @(negedge mclk) begin
    tickCnt <= tickCnt + 2'h1;
    rateTimerTick <= (tickCnt == 2'h0);
    // timer 1 stand-in: one overflow every two core clocks
    timer1Ovf <= !tickCnt[0];
  end

  function automatic logic [10:0] frm9(input logic [7:0] v, input logic n);
    return {1'b1, n, v, 1'b0};
  endfunction : frm9

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    sfrAddr = a;
    sfrWrData = v;
    sfrWrEn = 1'b1;
    @(negedge mclk);
    sfrWrEn = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge mclk);
    sfrAddr = a;
    sfrRdEn = 1'b1;
    @(negedge mclk);
    sfrRdEn = 1'b0;
    v = sfrRdData;
  endtask : rd

  task automatic t_regs();
    rd(SFR_SERIAL_CTRL, d);
    `CHK(d, SERIAL_CTRL_RST)
    wr(SFR_POWER_CTRL, 8'h81);
    rd(SFR_POWER_CTRL, d);
    `CHK(d, 8'h81)
    wr(SFR_POWER_CTRL, 8'h00);
    wr(8'h9A, 8'h55);
    rd(8'h9A, d);
    `CHK(d, 8'h00)
    `CHK(txdOut, 1'b1)
  endtask : t_regs

  task automatic t_shift();
    fork
      rem_u.shift_cap(b);
      wr(SFR_SERIAL_BUF, 8'h96);
    join
    `CHK(b, 8'h96)
    repeat (2 * SHIFT_MODE_DIV) @(negedge mclk);
    rd(SFR_SERIAL_CTRL, d);
    `CHK(d[CTL_TX_DONE], 1'b1)
    `CHK(rxdOe, 1'b0)
    fork
      wr(SFR_SERIAL_CTRL, 8'h10);
      rem_u.shift_feed(8'h3C);
    join
    repeat (2 * SHIFT_MODE_DIV) @(negedge mclk);
    rd(SFR_SERIAL_BUF, d);
    `CHK(d, 8'h3C)
    rd(SFR_SERIAL_CTRL, d);
    `CHK(d[CTL_RX_DONE], 1'b1)
    // a pending character must hold the shift clock still
    repeat (SHIFT_MODE_DIV) @(negedge mclk) `CHK(txdOut, 1'b1)
    wr(SFR_SERIAL_CTRL, 8'h00);
  endtask : t_shift

  task automatic t_m2tx();
    wr(SFR_SERIAL_CTRL, 8'h88);
    fork
      rem_u.cap(f, 11, FIXED_SLOW_DIV);
      wr(SFR_SERIAL_BUF, 8'hA5);
    join
    `CHK(f, frm9(8'hA5, 1'b1))
    rd(SFR_SERIAL_CTRL, d);
    `CHK(d[CTL_TX_DONE], 1'b1)
    repeat (FIXED_SLOW_DIV) @(negedge mclk);
    wr(SFR_POWER_CTRL, 8'h80);
    wr(SFR_SERIAL_CTRL, 8'h80);
    fork
      rem_u.cap(f, 11, FIXED_FAST_DIV);
      wr(SFR_SERIAL_BUF, 8'h5A);
    join
    `CHK(f, frm9(8'h5A, 1'b0))
    repeat (FIXED_FAST_DIV) @(negedge mclk);
    wr(SFR_POWER_CTRL, 8'h00);
  endtask : t_m2tx

  task automatic t_m3();
    wr(SFR_SERIAL_CTRL, 8'hC8);
    fork
      rem_u.cap(f, 11, PER_TICK);
      wr(SFR_SERIAL_BUF, 8'h69);
    join
    `CHK(f, frm9(8'h69, 1'b1))
    repeat (PER_TICK) @(negedge mclk);
    wr(SFR_POWER_CTRL, 8'h80);
    wr(SFR_SERIAL_CTRL, 8'hC0);
    fork
      rem_u.cap(f, 11, PER_TICK / 2);
      wr(SFR_SERIAL_BUF, 8'h96);
    join
    `CHK(f, frm9(8'h96, 1'b0))
    repeat (PER_TICK) @(negedge mclk);
    wr(SFR_POWER_CTRL, 8'h00);
    wr(SFR_SERIAL_CTRL, 8'h00);
  endtask : t_m3

  task automatic t_m2rx();
    wr(SFR_SERIAL_CTRL, 8'hA0);
    rem_u.send(frm9(8'h11, 1'b1), 11, FIXED_SLOW_DIV);
    rd(SFR_SERIAL_CTRL, d);
    `CHK(d[CTL_RX_DONE], 1'b0)
    wr(SFR_SERIAL_CTRL, 8'hB0);
    rem_u.send(frm9(8'h22, 1'b0), 11, FIXED_SLOW_DIV);
    rd(SFR_SERIAL_CTRL, d);
    `CHK(d[CTL_RX_DONE], 1'b0)
    rem_u.send(frm9(8'h33, 1'b1), 11, FIXED_SLOW_DIV);
    rd(SFR_SERIAL_CTRL, d);
    `CHK(d[2:0], 3'h5)
    rem_u.send(frm9(8'h44, 1'b1), 11, FIXED_SLOW_DIV);
    rd(SFR_SERIAL_BUF, d);
    `CHK(d, 8'h33)
    enhancedPortEnable = 1'b1;
    rem_u.send(frm9(8'h55, 1'b1), 11, FIXED_SLOW_DIV);
    `CHK(overwriteErr, 1'b1)
    rd(SFR_SERIAL_BUF, d);
    `CHK(d, 8'h55)
    `CHK(overwriteErr, 1'b0)
    enhancedPortEnable = 1'b0;
    wr(SFR_SERIAL_CTRL, 8'h00);
  endtask : t_m2rx

  task automatic t_m1();
    dedicatedRateGenEnable = 1'b1;
    wr(SFR_POWER_CTRL, 8'h80);
    wr(SFR_SERIAL_CTRL, 8'h50);
    fork
      rem_u.cap(f, 10, PER_TICK);
      wr(SFR_SERIAL_BUF, 8'hC3);
    join
    `CHK(f, frm9(8'hC3, 1'b1))
    rem_u.send(11'h000, 1, 8);
    // wait out a whole frame so a wrongly accepted start would show
    repeat (10 * PER_TICK) @(negedge mclk);
    rd(SFR_SERIAL_CTRL, d);
    `CHK(d[CTL_RX_DONE], 1'b0)
    wr(SFR_SERIAL_CTRL, 8'h70);
    rem_u.send(frm9(8'h5A, 1'b0), 10, PER_TICK);
    rd(SFR_SERIAL_CTRL, d);
    `CHK(d[CTL_RX_DONE], 1'b0)
    rem_u.send(frm9(8'hA6, 1'b1), 10, PER_TICK);
    rd(SFR_SERIAL_BUF, d);
    `CHK(d, 8'hA6)
    rd(SFR_SERIAL_CTRL, d);
    `CHK(d[2:0], 3'h5)
    wr(SFR_SERIAL_CTRL, 8'h00);
    dedicatedRateGenEnable = 1'b0;
  endtask : t_m1

  task automatic give_verdict();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    rst_b = 1'b0;
    sfrAddr = 8'h00;
    sfrWrEn = 1'b0;
    sfrWrData = 8'h00;
    sfrRdEn = 1'b0;
    dedicatedRateGenEnable = 1'b0;
    enhancedPortEnable = 1'b0;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    t_regs();
    t_shift();
    t_m2tx();
    t_m3();
    t_m2rx();
    t_m1();
    give_verdict();
  end

  initial begin
    repeat (40000) @(posedge mclk);
    failures++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
